// ===== hw/tmw_timer.sv
/*
  One-shot timer with wake-up request, wake cause flag and pin usage.
  Assumes configuration is plain ports from software logic, the pin
  input is asynchronous, and wake enables come from power management.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_timer
  import tmw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire tmw_cfg_t cfg_i,
  input wire tmw_lp_t lp_i,
  input wire logic clk_en_i,
  input wire logic go_set_i,
  input wire logic go_clr_i,
  input wire logic [CNT_W-1:0] compare_value_i,
  input wire logic cnt_wr_i,
  input wire logic [CNT_W-1:0] cnt_wr_data_i,
  input wire logic period_flag_clr_i,
  input wire logic wake_flag_clr_i,
  input wire logic wrdone_clr_i,
  input wire logic half_a_pin_i,
  output logic [CNT_W-1:0] count_value_o,
  output logic go_o,
  output logic clk_ok_o,
  output logic period_flag_o,
  output logic wrdone_o,
  output logic wake_flag_o,
  output logic lp_wake_status_o,
  output logic timer_interrupt_line_o,
  output logic wake_req_o,
  output tmw_pins_t pin_o,
  output tmw_pins_t pin_oe_o,
  output logic pin_event_o
);

  // Run state of the counter
  typedef enum logic [2:0] {
    TMW_IDLE = 3'b001,
    TMW_START = 3'b010,
    TMW_RUN = 3'b100
  } tmw_state_t;

  tmw_state_t state_q;
  tmw_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0] ok_cnt_q;
  logic [1:0] ok_cnt_d;
  logic clk_ok_q;
  logic clk_ok_d;
  logic period_flag_q;
  logic period_flag_d;
  logic wake_flag_q;
  logic wake_flag_d;
  logic lp_stat_q;
  logic lp_stat_d;
  logic wrdone_q;
  logic wrdone_d;
  logic pulse_q;
  logic pulse_d;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic tick;
  logic clk_run;
  logic period_end;
  logic one_shot;
  logic cnt_wr_ok;
  logic wake_gate;
  logic out_level;
  tmw_pin_use_t use_now;

  // Slow clock runs only while clock-off is low
  assign clk_run = clk_en_i && !(cfg_i.slow_timer && lp_i.lp_clock_off);
  assign one_shot = (cfg_i.mode == MODE_ONE_SHOT);
  assign use_now = mode_pin_use(cfg_i.mode);

  // Divider restarts at each start so every period has the same phase
  tmw_prescaler u_prescaler (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(clk_run && (state_q != TMW_IDLE)),
    .clk_div_i(cfg_i.clk_div),
    .tick_o(tick)
  );

  // End of period on the tick after count matched compare
  assign period_end = (state_q == TMW_RUN) && tick && one_shot
    && (cnt_q == compare_value_i);
  assign cnt_wr_ok = cnt_wr_i && clk_run;

  // Counter, run state and clock-ok next values
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    ok_cnt_d = ok_cnt_q;
    clk_ok_d = clk_ok_q;
    if (!clk_run)
    begin
      ok_cnt_d = 2'b00;
      clk_ok_d = 1'b0;
    end
    else if (ok_cnt_q != CLK_OK_DELAY[1:0])
    begin
      ok_cnt_d = ok_cnt_q + 2'b01;
    end
    else
    begin
      clk_ok_d = 1'b1;
    end
    case (state_q)
      TMW_IDLE:
      begin
        if (go_set_i && clk_ok_q)
        begin
          state_d = TMW_START;
        end
      end
      TMW_START:
      begin
        state_d = TMW_RUN;
      end
      TMW_RUN:
      begin
        if (period_end)
        begin
          state_d = TMW_IDLE;
          cnt_d = CNT_RELOAD;
        end
        else if (go_clr_i || !clk_run)
        begin
          state_d = TMW_IDLE;
        end
        else if (tick && one_shot)
        begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      default:
      begin
        state_d = TMW_IDLE;
      end
    endcase
    if (cnt_wr_ok && !period_end)
    begin
      cnt_d = cnt_wr_data_i;
    end
  end

  // Sticky flags; a set wins over a same-cycle clear
  always_comb
  begin
    period_flag_d = period_flag_q;
    wake_flag_d = wake_flag_q;
    lp_stat_d = lp_stat_q;
    wrdone_d = wrdone_q;
    if (period_flag_clr_i)
    begin
      period_flag_d = 1'b0;
    end
    if (period_end)
    begin
      period_flag_d = 1'b1;
    end
    if (wake_flag_clr_i)
    begin
      wake_flag_d = 1'b0;
      lp_stat_d = 1'b0;
    end
    if (period_end && wake_gate)
    begin
      wake_flag_d = 1'b1;
    end
    if (period_end && cfg_i.slow_timer)
    begin
      lp_stat_d = 1'b1;
    end
    if (wrdone_clr_i || cnt_wr_i)
    begin
      wrdone_d = 1'b0;
    end
    if (cnt_wr_ok)
    begin
      wrdone_d = 1'b1;
    end
  end

  assign pulse_d = period_end;

  // State registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_q <= TMW_IDLE;
      cnt_q <= CNT_RESET;
      ok_cnt_q <= 2'b00;
      clk_ok_q <= 1'b0;
      period_flag_q <= 1'b0;
      wake_flag_q <= 1'b0;
      lp_stat_q <= 1'b0;
      wrdone_q <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ok_cnt_q <= ok_cnt_d;
      clk_ok_q <= clk_ok_d;
      period_flag_q <= period_flag_d;
      wake_flag_q <= wake_flag_d;
      lp_stat_q <= lp_stat_d;
      wrdone_q <= wrdone_d;
      pulse_q <= pulse_d;
    end
  end

  // Pin input synchroniser and edge event
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= half_a_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_event_o = (use_now == TMW_PIN_IN) && (pin_s2_q ^ pin_s3_q);

  // Wake gating: standard uses allow bit, slow timer the two enables
  assign wake_gate = cfg_i.slow_timer
    ? (lp_i.lp_wake_allow && lp_i.pm_wake_allow)
    : cfg_i.wake_allow;
  assign wake_req_o = wake_flag_q && wake_gate;

  // Pin levels: idle at polarity, active for one source clock
  assign out_level = cfg_i.polarity ^ pulse_q;
  always_comb
  begin
    pin_o = '0;
    pin_oe_o = '0;
    if (use_now == TMW_PIN_OUT && clk_run)
    begin
      if (cfg_i.slow_timer)
      begin
        pin_o.slow_timer_pin = out_level;
        pin_oe_o.slow_timer_pin = cfg_i.out_en;
      end
      else
      begin
        pin_o.half_a_pin = out_level;
        pin_o.half_a_inverted_pin = !out_level;
        pin_o.half_b_pin = out_level;
        pin_o.half_b_inverted_pin = !out_level;
        pin_oe_o.half_a_pin = cfg_i.out_en;
        pin_oe_o.half_a_inverted_pin = cfg_i.out_inv_en;
        pin_oe_o.half_b_pin = cfg_i.out_en;
        pin_oe_o.half_b_inverted_pin = cfg_i.out_inv_en;
      end
    end
  end

  assign count_value_o = cnt_q;
  assign go_o = (state_q == TMW_RUN);
  assign clk_ok_o = clk_ok_q;
  assign period_flag_o = period_flag_q;
  assign wrdone_o = wrdone_q;
  assign wake_flag_o = wake_flag_q;
  assign lp_wake_status_o = lp_stat_q;
  assign timer_interrupt_line_o = period_flag_q && cfg_i.irq_en;

  // Period end event and its effects
  sequence s_end;
    period_end;
  endsequence

  a_end_reload: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_end |=> (cnt_q == CNT_RELOAD) && !go_o)
    else $error("count not reloaded or go not cleared");

  a_end_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_end |=> period_flag_o)
    else $error("period flag not set");

  a_pulse_width: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_end |=> pulse_q ##1 !pulse_q)
    else $error("output pulse not one cycle");

  a_wake_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    wake_req_o |-> wake_flag_o && wake_gate)
    else $error("wake without enable");

  a_irq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_interrupt_line_o |-> cfg_i.irq_en && period_flag_o)
    else $error("interrupt without enable");

  a_go_start: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == TMW_IDLE) && go_set_i && clk_ok_q && !period_end
      |-> !go_o ##1 !go_o ##1 go_o || !clk_run)
    else $error("go not read back two cycles after start");

  a_cnt_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    cnt_wr_ok && !period_end |=> wrdone_o
      && count_value_o == $past(cnt_wr_data_i))
    else $error("count write not applied");

  a_no_write_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    cnt_wr_i && !clk_run && state_q != TMW_RUN
      |=> $stable(count_value_o))
    else $error("count written while clock off");

  a_clk_ok: assert property (@(posedge mclk_i) disable iff (rst_i)
    !clk_run ##1 clk_run [*5] |-> clk_ok_o)
    else $error("clock ok not raised");

endmodule : tmw_timer
`default_nettype wire

// ===== inc/tmw_pkg.sv
/*
  Package for the one-shot wake-up timer: mode codes, widths, reset and
  reload values, prescaler limits and the carrier structs.
  Assumes one 250 MHz clock and a synchronous active-high reset.
*/
package tmw_pkg;

  localparam int CNT_W = 32;
  localparam int DIV_W = 12;
  localparam int MODE_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RELOAD = 32'h0000_0001;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
  localparam int PRESCALE_MAX = 4096;
  localparam logic [MODE_W-1:0] MODE_ONE_SHOT = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CONTINUOUS = 4'h1;
  localparam logic [MODE_W-1:0] MODE_COUNTER = 4'h2;
  localparam logic [MODE_W-1:0] MODE_PWM = 4'h3;
  localparam logic [MODE_W-1:0] MODE_CAPTURE = 4'h4;
  localparam logic [MODE_W-1:0] MODE_COMPARE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_GATED = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CAP_CMP = 4'h7;
  localparam logic [MODE_W-1:0] MODE_DUAL_EDGE = 4'h8;
  localparam logic [MODE_W-1:0] MODE_INACT_GATED = 4'he;
  localparam int CLK_OK_DELAY = 2;

  // Pin usage class of a mode
  typedef enum logic [2:0] {
    TMW_PIN_NONE = 3'b001,
    TMW_PIN_OUT = 3'b010,
    TMW_PIN_IN = 3'b100
  } tmw_pin_use_t;

  // Software configuration held outside the block
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [DIV_W-1:0] clk_div;
    logic polarity;
    logic out_en;
    logic out_inv_en;
    logic irq_en;
    logic wake_allow;
    logic slow_timer;
  } tmw_cfg_t;

  // Low-power wake gating from the power sequencer side
  typedef struct packed {
    logic lp_wake_allow;
    logic pm_wake_allow;
    logic lp_clock_off;
    logic lp_in_pin_en;
    logic lp_out_pin_en;
  } tmw_lp_t;

  // Pin enables and levels driven by the timer
  typedef struct packed {
    logic half_a_pin;
    logic half_a_inverted_pin;
    logic half_b_pin;
    logic half_b_inverted_pin;
    logic slow_timer_pin;
  } tmw_pins_t;

  // Pin usage of a mode for standard and low-power instances
  function automatic tmw_pin_use_t mode_pin_use(
    input logic [MODE_W-1:0] m
  );
    case (m)
      MODE_ONE_SHOT, MODE_CONTINUOUS, MODE_PWM, MODE_COMPARE:
        mode_pin_use = TMW_PIN_OUT;
      MODE_COUNTER, MODE_CAPTURE, MODE_GATED, MODE_CAP_CMP,
      MODE_DUAL_EDGE, MODE_INACT_GATED:
        mode_pin_use = TMW_PIN_IN;
      default:
        mode_pin_use = TMW_PIN_NONE;
    endcase
  endfunction : mode_pin_use

endpackage : tmw_pkg

// ===== hw/tmw_prescaler.sv
/*
  Prescaler: one-cycle enable every (clk_div + 1) source cycles.
  Assumes clk_div is held stable while running.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_prescaler
  import tmw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [DIV_W-1:0] clk_div_i,
  output logic tick_o
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  // Divide count, restarts when not running
  always_comb
  begin
    cnt_d = cnt_q;
    if (!run_i || cnt_q == clk_div_i)
    begin
      cnt_d = DIV_RESET;
    end
    else
    begin
      cnt_d = cnt_q + 12'h001;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= DIV_RESET;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Ratio is clk_div + 1, from 1 to 4096
  assign tick_o = run_i && (cnt_q == clk_div_i);

endmodule : tmw_prescaler
`default_nettype wire

// ===== tb/tmw_pm_model.sv
/*
  Clock-control and power-management model facing the wake-up timer.
  Assumes the bench commands the wake enables and the slow clock gate.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_pm_model
  import tmw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic lp_allow_i,
  input wire logic pm_allow_i,
  input wire logic clk_off_i,
  input wire logic wake_req_i,
  output tmw_lp_t lp_o,
  output logic active_o
);
  logic active_d;
  logic active_q;

  // Wake gates and low-power pin enables as software would set them
  always_comb
  begin
    lp_o.lp_wake_allow = lp_allow_i;
    lp_o.pm_wake_allow = pm_allow_i;
    lp_o.lp_clock_off = clk_off_i;
    lp_o.lp_in_pin_en = slow_i & ~clk_off_i;
    lp_o.lp_out_pin_en = slow_i & ~clk_off_i;
    active_d = active_q | wake_req_i;
  end

  // Restart request seen by clock control
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      active_q <= 1'b0;
    else
      active_q <= active_d;
  end

  assign active_o = active_q;
endmodule : tmw_pm_model
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the one-shot wake-up timer.
  Assumes a 250 MHz clock and the power model on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmw_pkg::*;
  logic mclk_i, rst_i, clk_en, pin_in, lp_allow, pm_allow, clk_off;
  logic go, clk_ok, pflag, wrdone, wflag, lpst, irq, wreq, pev, active;
  logic [5:0] pls;
  logic [31:0] seed, r;
  logic [CNT_W-1:0] cmp, wdata, count;
  tmw_cfg_t cfg;
  tmw_lp_t lp;
  tmw_pins_t pin, pin_oe;
  int miscompares, checks, pulses, d0, d1, s, m, n;

  tmw_timer tmw_timer_i (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_i(cfg),
    .lp_i(lp), .clk_en_i(clk_en), .go_set_i(pls[0]), .go_clr_i(pls[1]),
    .compare_value_i(cmp), .cnt_wr_i(pls[2]), .cnt_wr_data_i(wdata),
    .period_flag_clr_i(pls[3]), .wake_flag_clr_i(pls[4]),
    .wrdone_clr_i(pls[5]), .half_a_pin_i(pin_in), .count_value_o(count),
    .go_o(go), .clk_ok_o(clk_ok), .period_flag_o(pflag), .wrdone_o(wrdone),
    .wake_flag_o(wflag), .lp_wake_status_o(lpst),
    .timer_interrupt_line_o(irq), .wake_req_o(wreq), .pin_o(pin),
    .pin_oe_o(pin_oe), .pin_event_o(pev));

  tmw_pm_model tmw_pm_model_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .slow_i(cfg.slow_timer), .lp_allow_i(lp_allow), .pm_allow_i(pm_allow),
    .clk_off_i(clk_off), .wake_req_i(wreq), .lp_o(lp), .active_o(active));

  // Clock
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Cycles in which the output pin leaves its idle level
  always @(posedge mclk_i)
    if ((cfg.slow_timer ? pin.slow_timer_pin : pin.half_a_pin) !== cfg.polarity)
      pulses <= pulses + 1;

  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle request on strobe b
  task automatic pulse(input int b);
    @(posedge mclk_i);
    pls[b] <= 1'b1;
    @(posedge mclk_i);
    pls <= '0;
  endtask : pulse

  // Bounded wait: 0 clock ok, 1 write done, 2 go high, 3 go low
  task automatic wait_sig(input int sel);
    int k;
    k = 0;
    while (!(sel == 0 ? clk_ok === 1'b1 : sel == 1 ? wrdone === 1'b1 :
             sel == 2 ? go === 1'b1 : go === 1'b0) && k < 20000)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    if (k >= 20000)
    begin
      miscompares++;
      summarize();
    end
  endtask : wait_sig

  // One one-shot period; returns cycles with go high
  task automatic run(output int dur);
    logic ew;
    ew = cfg.wake_allow & (cfg.slow_timer ? lp_allow & pm_allow : 1'b1);
    pulse(0);
    #1;
    wait_sig(2);
    dur = 0;
    pulses = 0;
    while (go === 1'b1 && dur < 20000)
    begin
      @(posedge mclk_i);
      #1;
      dur++;
    end
    wait_sig(3);
    chk(count, CNT_RELOAD);
    chk(pflag, 1'b1);
    chk(irq, cfg.irq_en);
    chk(wflag, ew);
    chk(wreq, ew);
    if (cfg.slow_timer)
      chk(lpst, 1'b1);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(pulses, 1);
    chk(pflag, 1'b1);
    chk(wreq, ew);
    chk(active, ew | active);
    pulse(3);
    pulse(4);
    #1;
    chk({pflag, irq, wreq}, 3'b000);
  endtask : run

  initial
  begin
    seed = 32'h636f;
    miscompares = 0;
    checks = 0;
    pulses = 0;
    rst_i = 1'b1;
    clk_en = 1'b0;
    pls = '0;
    pin_in = 1'b0;
    lp_allow = 1'b1;
    pm_allow = 1'b1;
    clk_off = 1'b0;
    cmp = 32'h0000_0005;
    wdata = 32'h0000_0000;
    cfg = '0;
    cfg.out_en = 1'b1;
    cfg.irq_en = 1'b1;
    cfg.wake_allow = 1'b1;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(count, CNT_RESET);
    chk({go, pflag, wflag, wreq}, 4'h0);
    pulse(0);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(go, 1'b0);
    @(posedge mclk_i);
    clk_en <= 1'b1;
    wait_sig(0);
    run(d0);
    run(d1);
    chk(32'(d0 - d1), 32'(1));
    // Random trials: prescale, compare, start value, gates
    for (int t = 0; t < 6; t++)
    begin
      r = $random(seed);
      @(posedge mclk_i);
      cfg.clk_div <= {9'h000, r[2:0]};
      cmp <= {27'h000_0000, 1'b1, r[6:3]} + 32'h0000_0002;
      cfg.polarity <= r[7];
      cfg.irq_en <= r[8];
      cfg.slow_timer <= t[0];
      cfg.wake_allow <= r[9] | t[0];
      lp_allow <= r[10] | ~t[0];
      pm_allow <= r[11] | ~t[0];
      wdata <= {28'h000_0000, r[15:12]} % 32'h0000_0008 + 32'h0000_0001;
      @(posedge mclk_i);
      s = int'(wdata);
      pulse(2);
      #1;
      wait_sig(1);
      pulse(5);
      run(d0);
      run(d1);
      chk(32'(d1 - d0), 32'((s - 1) * (int'(cfg.clk_div) + 1)));
    end
    // Count write refused while the slow clock is off
    @(posedge mclk_i);
    cfg.slow_timer <= 1'b1;
    clk_off <= 1'b1;
    wdata <= 32'h0000_00aa;
    pulse(2);
    repeat (3) @(posedge mclk_i);
    #1;
    chk(wrdone, 1'b0);
    chk(count, CNT_RELOAD);
    clk_off <= 1'b0;
    // Pin direction and input events of every mode code
    for (int k = 0; k < 32; k++)
    begin
      m = k % 16;
      @(posedge mclk_i);
      cfg.mode <= 4'(m);
      cfg.slow_timer <= k[4];
      repeat (3) @(posedge mclk_i);
      #1;
      chk(k[4] ? pin_oe.slow_timer_pin : pin_oe.half_a_pin,
          m inside {0, 1, 3, 5});
      n = 0;
      pin_in <= ~pin_in;
      repeat (6)
      begin
        @(posedge mclk_i);
        #1;
        n += (pev === 1'b1);
      end
      chk(n, m inside {2, 4, 6, 7, 8, 14});
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
